// ---- hdl/scr_pkg.sv ----
// package: register map, codes and field layouts of the safety/config register set
package scr_pkg;
  localparam logic [8:0]  ADDR_LOCK        = 9'h1cd;
  localparam logic [8:0]  ADDR_RDCLR       = 9'h1ce;
  localparam logic [8:0]  ADDR_UNLOCK      = 9'h1cf;
  localparam logic [8:0]  ADDR_GRST1       = 9'h1d0;
  localparam logic [8:0]  ADDR_GRST2       = 9'h1d1;
  localparam logic [8:0]  ADDR_RST_CAUSE   = 9'h1d6;
  localparam logic [8:0]  ADDR_SELFTEST    = 9'h1dc;
  localparam logic [8:0]  ADDR_UNLOCK_CH1  = 9'h103;
  localparam logic [8:0]  ADDR_UNLOCK_CH2  = 9'h123;
  localparam logic [15:0] KEY_SELFTEST     = 16'hb157;
  localparam logic [15:0] KEY_CODE_RAM     = 16'hbeef;
  localparam logic [15:0] KEY_UNLOCK       = 16'h1337;
  localparam logic [15:0] KEY_GRST1        = 16'hf473;
  localparam logic [15:0] KEY_GRST2        = 16'h57a1;
  // lock register fields
  localparam int          LOCK_DEV         = 0;
  localparam int          LOCK_DRAM1       = 1;
  localparam int          LOCK_DRAM2       = 2;
  localparam int          LOCK_W           = 3;
  localparam logic [2:0]  LOCK_RESET       = 3'h0;
  // read-clear select field
  localparam int          RDCLR_W          = 9;
  localparam logic [8:0]  RDCLR_RESET      = 9'h000;
  // reset-cause fields
  localparam int          CAUSE_PIN        = 0;
  localparam int          CAUSE_POR        = 1;
  localparam int          CAUSE_SPI        = 2;
  localparam int          CAUSE_W          = 3;
  // data ram private tail
  localparam int          DRAM_TAIL_WORDS  = 16;
  // self-test timing and patterns
  localparam real         SELFTEST_MS      = 2.2;
  localparam real         SELFTEST_REF_MHZ = 24.0;
  localparam int          SELFTEST_CYCLES  = int'(SELFTEST_MS * SELFTEST_REF_MHZ * 1000.0);
  localparam int          NUM_TESTS        = 5;
  localparam logic [7:0]  PAT_FIRST [NUM_TESTS] = '{8'h00, 8'h55, 8'h0f, 8'h00, 8'hff};
  localparam logic [7:0]  PAT_SECOND[NUM_TESTS] = '{8'h11, 8'haa, 8'hf0, 8'hff, 8'h00};

  typedef enum logic [1:0] {
    ST_NEVER = 2'b00,
    ST_BUSY  = 2'b01,
    ST_PASS  = 2'b10,
    ST_FAIL  = 2'b11
  } scr_outcome_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ext;
    logic [8:0]  addr;
    logic [15:0] wdata;
  } scr_req_t;

  typedef struct packed {
    logic        run;
    logic [7:0]  pattern;
  } scr_ramtest_t;
endpackage

// ---- hdl/scr_safety_regs.sv ----
// module: reset-cause, self-test launcher, write lock and read-clear configuration
`timescale 1ns/1ps

// Summary of operation
// - three sticky reset-cause flags record each reset source since last access
// - any external access to reset-cause clears its flags afterwards, except a flag whose source is active in that cycle
// - bit 2 spi global reset, bit 1 power-on, bit 0 reset pin
// - reset-pin flag undefined after power-on until next clear
// - writing key b157 to self-test address launches memory test
// - launch accepted only when both code rams unlocked with beef
// - self-test progress and outcome readable anytime at same address
// - full self-test takes about 2.2 ms at 24 mhz
// - five ram tests with pattern pairs 00/11 55/aa 0f/f0 00/ff ff/00
// - outcome 00 never, 01 running, 10 passed, 11 failed
// - lock active makes lockable registers read-only over spi
// - writing one to lock bit 0 enables protection; writes cannot clear it
// - writing 1337 to unlock register clears whole lock register
// - data ram tails protected only by lock bits 1 and 2
// - read-clear select bits choose which status registers clear on read; bit 0 driver status
// - bits 1 to 4 select diagnosis pairs 162/163 through 168/169
// - bits 5 to 8 select core status registers ch1 core0,1 then ch2
// - microcore back-door reads never clear read-clear registers
// - external read colliding with core write returns old value, back-door read keeps previous read word; new value next read
module scr_safety_regs #(
  parameter int CLK_MHZ         = 200,
  parameter int SELFTEST_LEN    = scr_pkg::SELFTEST_CYCLES * CLK_MHZ / 24
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  power_on_reset_n,
  input  wire logic                  reset_pin_n,
  input  wire logic                  spi_global_reset,
  input  wire scr_pkg::scr_req_t     req,
  input  wire logic                  core_write_same,
  input  wire logic                  ram_test_fail,
  output      logic [15:0]           rdata,
  output      logic                  write_allowed,
  output      logic                  dram1_tail_write_allowed,
  output      logic                  dram2_tail_write_allowed,
  output      logic                  lockable_locked,
  output      logic [8:0]            read_clear_select,
  output      logic [8:0]            clear_on_read_pulse,
  output      scr_pkg::scr_ramtest_t ram_test,
  output      scr_pkg::scr_outcome_t selftest_outcome
);
  import scr_pkg::*;

  logic [LOCK_W-1:0]  lock_reg;
  logic [RDCLR_W-1:0] rdclr_reg;
  logic [CAUSE_W-1:0] cause_reg;
  logic               code_ram1_open_reg;
  logic               code_ram2_open_reg;
  logic [31:0]        tick_reg;
  logic [2:0]         test_idx_reg;
  logic               phase_reg;
  logic               fail_seen_reg;
  logic [15:0]        rdata_next;
  logic               wr_lock;
  logic               wr_rdclr;
  logic               wr_unlock;
  logic               launch;

  typedef enum logic [1:0] {S_IDLE, S_RUN} scr_st_t;
  scr_st_t st_reg;

  localparam int PHASE_LEN = SELFTEST_LEN / (NUM_TESTS * 2);

  assign wr_lock   = req.wr && req.ext && req.addr == ADDR_LOCK;
  assign wr_rdclr  = req.wr && req.ext && req.addr == ADDR_RDCLR;
  assign wr_unlock = req.wr && req.ext && req.addr == ADDR_UNLOCK && req.wdata == KEY_UNLOCK;
  // both code rams must be open
  assign launch    = req.wr && req.ext && req.addr == ADDR_SELFTEST && req.wdata == KEY_SELFTEST
                     && code_ram1_open_reg && code_ram2_open_reg && st_reg == S_IDLE;

  // lock bits are set-only from the bus; tails too
  // only the unlock key clears them, all at once
  genvar li;
  generate
    for (li = 0; li < LOCK_W; li++)
    begin : g_lock
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          lock_reg[li] <= LOCK_RESET[li];
        else if (wr_unlock)
          lock_reg[li] <= LOCK_RESET[li];
        else if (wr_lock && req.wdata[li])
          lock_reg[li] <= 1'b1;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdclr_reg <= RDCLR_RESET;
    else if (wr_rdclr)
      rdclr_reg <= req.wdata[RDCLR_W-1:0];
  end

  // code ram unlock words tracked for self-test gating, one flag per channel
  localparam int         CODE_RAMS                = 2;
  localparam logic [8:0] UNLOCK_ADDR [CODE_RAMS]  = '{ADDR_UNLOCK_CH1, ADDR_UNLOCK_CH2};
  logic [CODE_RAMS-1:0]  code_ram_open;
  genvar ci;
  generate
    for (ci = 0; ci < CODE_RAMS; ci++)
    begin : g_code_ram
      // last write wins; any other word closes the gate again
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          code_ram_open[ci] <= 1'b0;
        else if (req.wr && req.ext && req.addr == UNLOCK_ADDR[ci])
          code_ram_open[ci] <= req.wdata == KEY_CODE_RAM;
      end
    end
  endgenerate
  assign code_ram1_open_reg = code_ram_open[0];
  assign code_ram2_open_reg = code_ram_open[1];

  // per-source set and shared clear of the sticky flags
  logic [CAUSE_W-1:0] cause_set;
  logic               cause_access;
  assign cause_access = req.ext && (req.rd || req.wr) && req.addr == ADDR_RST_CAUSE;
  assign cause_set[CAUSE_PIN] = !reset_pin_n;
  assign cause_set[CAUSE_POR] = !power_on_reset_n;
  // global reset request decoded upstream, arrives as a level
  assign cause_set[CAUSE_SPI] = spi_global_reset;

  // sticky causes; flags sampled while in reset, so no async reset
  // pin flag unknown after power-on: left as sampled
  genvar gi;
  generate
    for (gi = 0; gi < CAUSE_W; gi++)
    begin : g_cause
      always_ff @(posedge clk)
      begin
        if (cause_set[gi])
          cause_reg[gi] <= 1'b1;
        // spi history means nothing after a power loss
        else if (gi == CAUSE_SPI && !power_on_reset_n)
          cause_reg[gi] <= 1'b0;
        // cleared on any external access; a source in the same cycle wins
        else if (cause_access)
          cause_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // self-test sequencing helpers
  logic phase_end;
  logic last_phase;
  logic run_done;
  assign phase_end  = st_reg == S_RUN && tick_reg == 32'(PHASE_LEN - 1);
  assign last_phase = phase_reg && test_idx_reg == 3'(NUM_TESTS - 1);
  assign run_done   = phase_end && last_phase;

  // launch on key write; state only, counters below
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= S_IDLE;
    else
    begin
      case (st_reg)
        S_IDLE:
        begin
          if (launch)
            st_reg <= S_RUN;
        end
        S_RUN:
        begin
          if (run_done)
            st_reg <= S_IDLE;
        end
        default:
          st_reg <= S_IDLE;
      endcase
    end
  end

  // phase length from clock rate; one counter shared by all phases
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tick_reg <= '0;
    else if (launch || phase_end)
      tick_reg <= '0;
    else if (st_reg == S_RUN)
      tick_reg <= tick_reg + 32'h1;
  end

  // first pattern then second, five tests in order
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_reg    <= 1'b0;
      test_idx_reg <= '0;
    end
    else if (launch)
    begin
      phase_reg    <= 1'b0;
      test_idx_reg <= '0;
    end
    else if (phase_end)
    begin
      phase_reg <= ~phase_reg;
      // index parks on the last test until the next launch
      if (phase_reg && !last_phase)
        test_idx_reg <= test_idx_reg + 3'h1;
    end
  end

  // failure memory over the whole run
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fail_seen_reg <= 1'b0;
    else if (launch)
      fail_seen_reg <= 1'b0;
    else if (st_reg == S_RUN && ram_test_fail)
      fail_seen_reg <= 1'b1;
  end

  // outcome code: busy on launch, pass or fail at the end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      selftest_outcome <= ST_NEVER;
    else if (launch)
      selftest_outcome <= ST_BUSY;
    else if (run_done)
      // a mismatch in the final cycle still counts
      selftest_outcome <= (fail_seen_reg || ram_test_fail) ? ST_FAIL : ST_PASS;
  end

  always_comb
  begin
    ram_test.run     = st_reg == S_RUN;
    ram_test.pattern = phase_reg ? PAT_SECOND[test_idx_reg] : PAT_FIRST[test_idx_reg];
  end

  // lockable registers writable only without lock
  assign lockable_locked          = lock_reg[LOCK_DEV];
  assign write_allowed            = !lock_reg[LOCK_DEV];
  assign dram1_tail_write_allowed = !lock_reg[LOCK_DRAM1];
  assign dram2_tail_write_allowed = !lock_reg[LOCK_DRAM2];
  assign read_clear_select        = rdclr_reg;

  // one strobe per selectable register, external reads only
  // back-door reads (ext low) never clear
  genvar ri;
  generate
    for (ri = 0; ri < RDCLR_W; ri++)
    begin : g_clear_strobe
      assign clear_on_read_pulse[ri] = req.rd && req.ext && rdclr_reg[ri];
    end
  endgenerate

  always_comb
  begin
    rdata_next = 16'h0000;
    case (req.addr)
      ADDR_LOCK:      rdata_next[LOCK_W-1:0]  = lock_reg;
      ADDR_RDCLR:     rdata_next[RDCLR_W-1:0] = rdclr_reg;
      ADDR_RST_CAUSE: rdata_next[CAUSE_W-1:0] = cause_reg;
      ADDR_SELFTEST:  rdata_next[1:0]         = selftest_outcome;
      default:        rdata_next              = 16'h0000;
    endcase
  end

  // data captured from pre-update contents; a same-cycle core write shows next read
  logic rd_capture;
  // back-door reads colliding with a core write keep the old word
  assign rd_capture = req.rd && !(core_write_same && !req.ext);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 16'h0000;
    else if (rd_capture)
      rdata <= rdata_next;
  end
endmodule // scr_safety_regs

// ---- testbench/scr_safety_monitor.sv ----
// checker: port-level assertions for the safety/config register set
`timescale 1ns/1ps
module scr_safety_monitor
  import scr_pkg::*;
#(
  parameter int SELFTEST_LEN = 100
) (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic                  power_on_reset_n,
  input wire logic                  reset_pin_n,
  input wire logic                  spi_global_reset,
  input wire scr_pkg::scr_req_t     req,
  input wire logic [15:0]           rdata,
  input wire logic                  write_allowed,
  input wire logic                  lockable_locked,
  input wire logic [8:0]            read_clear_select,
  input wire logic [8:0]            clear_on_read_pulse,
  input wire scr_pkg::scr_ramtest_t ram_test,
  input wire scr_pkg::scr_outcome_t selftest_outcome
);
  localparam int DONE_MAX = SELFTEST_LEN + 2;
  logic quiet;
  logic rd_cause;
  logic unlock_wr;
  assign quiet = power_on_reset_n && reset_pin_n && !spi_global_reset;
  assign rd_cause = req.rd && req.ext && req.addr == ADDR_RST_CAUSE && quiet;
  assign unlock_wr = req.wr && req.ext && req.addr == ADDR_UNLOCK && req.wdata == KEY_UNLOCK;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  cause_clears_a: assert property (rd_cause ##1 quiet ##1 rd_cause |=> rdata[2:0] == 3'h0)
    else $error("reset cause kept after access");
  lock_sticky_a: assert property (lockable_locked && !unlock_wr |=> lockable_locked)
    else $error("lock bit cleared without key");
  unlock_clear_a: assert property (unlock_wr |=> !lockable_locked)
    else $error("unlock key did not clear lock");
  write_gate_a: assert property (write_allowed == !lockable_locked)
    else $error("write gate disagrees with lock");
  rdclr_pulse_a: assert property (clear_on_read_pulse == ((req.rd && req.ext) ? read_clear_select : 9'h000))
    else $error("clear on read pulse wrong");
  busy_run_a: assert property (selftest_outcome == ST_BUSY |-> ram_test.run)
    else $error("busy without ram test running");
  busy_end_a: assert property ((selftest_outcome == ST_BUSY) ##1 (selftest_outcome != ST_BUSY) |-> selftest_outcome[1])
    else $error("self-test left busy to bad code");
  busy_bound_a: assert property ($rose(selftest_outcome == ST_BUSY) |-> ##[1:DONE_MAX] selftest_outcome != ST_BUSY)
    else $error("self-test overran its length");
  bad_key_a: assert property (req.wr && req.addr == ADDR_SELFTEST && req.wdata != KEY_SELFTEST |=> $stable(selftest_outcome))
    else $error("wrong key changed self-test");
  cover property ($rose(ram_test.run));
  cover property (unlock_wr);
  cover property (|clear_on_read_pulse);
endmodule // scr_safety_monitor

bind scr_safety_regs scr_safety_monitor #(.SELFTEST_LEN(SELFTEST_LEN)) mon (.clk(clk), .nrst(nrst),
  .power_on_reset_n(power_on_reset_n), .reset_pin_n(reset_pin_n), .spi_global_reset(spi_global_reset),
  .req(req), .rdata(rdata), .write_allowed(write_allowed), .lockable_locked(lockable_locked),
  .read_clear_select(read_clear_select), .clear_on_read_pulse(clear_on_read_pulse),
  .ram_test(ram_test), .selftest_outcome(selftest_outcome));

// ---- testbench/scr_host.sv ----
// partner model: external microcontroller issuing register accesses
`timescale 1ns/1ps
module scr_host
  import scr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [15:0]       rdata,
  output      scr_pkg::scr_req_t req
);
  initial req = '0;
  task automatic acc(input logic r, input logic w, input logic e, input logic [8:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    req <= '{rd: r, wr: w, ext: e, addr: a, wdata: d};
    @(posedge clk);
    #1;
    q = rdata;
    @(negedge clk);
    req <= '0;
  endtask
endmodule // scr_host

// ---- testbench/tb.sv ----
// testbench: register-level scenarios for the safety/config register set
`timescale 1ns/1ps
module tb;
  import scr_pkg::*;
  logic         clk, nrst, por_n, pin_n, grst, fail, wa, d1, d2, lk;
  logic [15:0]  rdata, q;
  logic [8:0]   rcs, crp, crp_seen;
  logic         cws;
  logic [7:0]   pq[$], eq[$];
  scr_req_t     req;
  scr_ramtest_t rt;
  scr_outcome_t so;
  int           err_count = 0;
  int           checks_done = 0;
  scr_safety_regs #(.SELFTEST_LEN(100)) dut (.clk(clk), .nrst(nrst), .power_on_reset_n(por_n),
    .reset_pin_n(pin_n), .spi_global_reset(grst), .req(req), .core_write_same(cws), .ram_test_fail(fail),
    .rdata(rdata), .write_allowed(wa), .dram1_tail_write_allowed(d1), .dram2_tail_write_allowed(d2),
    .lockable_locked(lk), .read_clear_select(rcs), .clear_on_read_pulse(crp), .ram_test(rt), .selftest_outcome(so));
  scr_host host (.clk(clk), .rdata(rdata), .req(req));
  // strobe captured while the read request stands
  always @(posedge clk)
  begin
    if (req.rd)
      crp_seen <= crp;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [8:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    host.acc(1'b1, 1'b0, 1'b1, a, 16'h0000, q);
    chk($sformatf("reg %h", a), e, q & m);
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    host.acc(1'b0, 1'b1, 1'b1, a, d, q);
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // watchdog: run needs about 300 cycles
  initial
  begin
    #20000;
    err_count++;
    stop_test;
  end
  initial
  begin
    {nrst, por_n, pin_n, grst, fail} = 5'b00100;
    cws = 1'b0;
    repeat (6) @(negedge clk);
    por_n = 1;
    nrst = 1;
    rc(ADDR_LOCK, 16'h0000);
    rc(ADDR_SELFTEST, 16'h0000);
    rc(ADDR_RST_CAUSE, 16'h0002, 16'hfffe);
    rc(ADDR_RST_CAUSE, 16'h0000);
    @(negedge clk) pin_n = 0;
    @(negedge clk) pin_n = 1;
    rc(ADDR_RST_CAUSE, 16'h0001);
    // global reset level from upstream decode
    @(negedge clk) grst = 1;
    @(negedge clk) grst = 0;
    rc(ADDR_RST_CAUSE, 16'h0004);
    $display("reset cause test done");
    wr(ADDR_SELFTEST, KEY_SELFTEST);
    rc(ADDR_SELFTEST, 16'h0000);
    wr(ADDR_UNLOCK_CH1, KEY_CODE_RAM);
    wr(ADDR_UNLOCK_CH2, KEY_CODE_RAM);
    wr(ADDR_SELFTEST, 16'h1234);
    rc(ADDR_SELFTEST, 16'h0000);
    wr(ADDR_SELFTEST, KEY_SELFTEST);
    rc(ADDR_SELFTEST, 16'h0001);
    for (int i = 0; i < 120; i++)
    begin
      @(posedge clk);
      #1;
      if (rt.run === 1'b1 && (pq.size() == 0 || pq[$] !== rt.pattern)) pq.push_back(rt.pattern);
    end
    // expected pattern order, adjacent repeats merged
    for (int i = 0; i < NUM_TESTS; i++)
    begin
      if (eq.size() == 0 || eq[$] !== PAT_FIRST[i]) eq.push_back(PAT_FIRST[i]);
      if (eq[$] !== PAT_SECOND[i]) eq.push_back(PAT_SECOND[i]);
    end
    chk("phases", 16'(eq.size()), 16'(pq.size()));
    foreach (eq[i]) chk("pattern", {8'h00, eq[i]}, {8'h00, pq[i]});
    rc(ADDR_SELFTEST, 16'h0002);
    fail = 1;
    wr(ADDR_SELFTEST, KEY_SELFTEST);
    repeat (110) @(negedge clk);
    rc(ADDR_SELFTEST, 16'h0003);
    $display("self-test test done");
    wr(ADDR_LOCK, 16'h0001);
    chk("write gate", 16'h0000, {15'h0, wa});
    chk("tail gate", 16'h0001, {15'h0, d1});
    wr(ADDR_LOCK, 16'h0000);
    rc(ADDR_LOCK, 16'h0001);
    wr(ADDR_LOCK, 16'h0006);
    chk("tails", 16'h0000, {14'h0, d1, d2});
    wr(ADDR_LOCK, 16'h0000);
    rc(ADDR_LOCK, 16'h0007);
    wr(ADDR_UNLOCK, 16'h1336);
    rc(ADDR_LOCK, 16'h0007);
    wr(ADDR_UNLOCK, KEY_UNLOCK);
    rc(ADDR_LOCK, 16'h0000);
    chk("gates", 16'h0007, {13'h0, wa, d1, d2});
    $display("lock test done");
    wr(ADDR_RDCLR, 16'hffff);
    rc(ADDR_RDCLR, 16'h01ff);
    chk("select", 16'h01ff, {7'h00, rcs});
    chk("clear strobe", 16'h01ff, {7'h00, crp_seen});
    @(negedge clk) cws = 1'b1;
    host.acc(1'b1, 1'b0, 1'b0, ADDR_LOCK, 16'h0000, q);
    chk("held read", 16'h01ff, q);
    chk("back-door strobe", 16'h0000, {7'h00, crp_seen});
    cws = 1'b0;
    $display("read clear test done");
    stop_test;
  end
endmodule // tb
